/* File: rtl/prs_power_ctrl.sv */
// prs_power_ctrl: chip enable, power request and multi-io sequencing with apb registers
// assumes sys_clk at 10 MHz, synchronous reset from power-on reset, pins asynchronous
//
// Overview of operation
// - chip enable low disables, pins float
// - enable falling runs power-down, shutdown, standby, then off
// - enable back during its power-down restarts power-up
// - shutdown period after last output off
// - other power-downs ignore short enable dips
// - switch mode is level with selectable polarity
// - push-button needs hold of 1, 1.5, 2, 3 s
// - request goes wake delay then power-up
// - request removal powers down in configured order
// - per-pin on and off delays 0-127 ms
// - per-pin polarity bit applies to function, not to gp input, gp output or clock output
// - gp input readable, gp output driven from register
// - two-bit drive type selects output style
// - lock ignores config writes, reads still work
// - lock stays set until power-on reset
// - special functions only on their own pin
// - disabled pin floats, functions may repeat
// - late power-good on power-up freezes timers
// - late power-good on power-down freezes timers
// - only outputs with larger delay are frozen
// - delay grows by largest power-good lateness
// - sequencer request is enable, request, no fault, no resets
// - wake delay about 80 us before power-up
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module prs_power_ctrl #(
   parameter int MS_DIV = prs_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          sys_rst,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [prs_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // control pins
   input  wire logic                          chip_enable_in,
   input  wire logic                          power_request_in,
   input  wire logic                          low_freq_clock_in,
   // internal status from the rest of the device
   input  wire logic                          fault_in,
   input  wire logic [prs_pkg::NUM_PINS-1:0]  rail_good_in,
   // multi-io pins
   input  wire logic [prs_pkg::NUM_PINS-1:0]  multi_io_pin_in,
   output logic      [prs_pkg::NUM_PINS-1:0]  multi_io_pin_out,
   output logic      [prs_pkg::NUM_PINS-1:0]  multi_io_pin_oe,
   // sequencer results
   output logic                               rail_enable,
   output logic                               discharge_enable,
   output logic                               sequencer_power_request,
   output logic      [6:0]                    seq_state,
   output logic                               sleep_req,
   output logic                               watchdog_kick_in,
   output logic                               host_reset_in
);
   import prs_pkg::*;

   // synchronisers
   logic [NUM_PINS+2:0] sync_a;
   logic [NUM_PINS+2:0] sync_b;
   logic [NUM_PINS-1:0] pin_prev;
   logic                ce_s;
   logic                pwr_s;
   logic                lfc_s;
   logic [NUM_PINS-1:0] pin_s;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sync_a   <= '0;
         sync_b   <= '0;
         pin_prev <= '0;
      end else begin
         sync_a   <= {low_freq_clock_in, power_request_in, chip_enable_in, multi_io_pin_in};
         sync_b   <= sync_a;
         pin_prev <= pin_s;
      end
   end
   assign pin_s = sync_b[NUM_PINS-1:0];
   assign ce_s  = sync_b[NUM_PINS];
   assign pwr_s = sync_b[NUM_PINS+1];
   assign lfc_s = sync_b[NUM_PINS+2];

   // millisecond tick
   logic [15:0] ms_cnt;
   logic        ms_tick;
   always_ff @(posedge sys_clk) begin
      if (sys_rst || ms_cnt == 16'(MS_DIV - 1)) begin
         ms_cnt <= '0;
      end else begin
         ms_cnt <= ms_cnt + 16'h0001;
      end
   end
   always_ff @(posedge sys_clk) begin
      ms_tick <= !sys_rst && (ms_cnt == 16'(MS_DIV - 1));
   end

   // registers
   logic [7:0]       ctrl;
   logic [7:0]       cfg     [NUM_PINS];
   logic [DLY_W-1:0] on_dly  [NUM_PINS];
   logic [DLY_W-1:0] off_dly [NUM_PINS];
   logic [DLY_W-1:0] shut_dly;
   logic [NUM_PINS-1:0] out_value;
   logic             lock;
   logic [IDX_W-1:0] idx;
   logic             wr_en;
   logic             aligned;
   assign idx     = paddr[ADDR_W-1:2];
   assign aligned = (paddr[1:0] == 2'h0);
   assign wr_en   = psel && penable && pready && pwrite && aligned;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctrl      <= CTRL_RESET;
         shut_dly  <= DLY_RESET;
         out_value <= '0;
      end else if (wr_en) begin
         if (idx == IDX_CTRL)      ctrl      <= pwdata[7:0];
         if (idx == IDX_SHUTDOWN)  shut_dly  <= pwdata[DLY_W-1:0];
         if (idx == IDX_OUT_VALUE) out_value <= pwdata[NUM_PINS-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lock <= 1'b0;
      end else if (wr_en && idx == IDX_LOCK) begin
         lock <= lock | pwdata[0];
      end
   end

   // read mux
   logic [31:0] rd_val;
   logic        rd_hit;
   logic [NUM_PINS-1:0] in_state;

   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = aligned;
      case (idx)
         IDX_CTRL:      rd_val[7:0]          = ctrl;
         IDX_STATUS:    rd_val[8:0]          = {lock, sequencer_power_request, seq_state};
         IDX_IN_STATE:  rd_val[NUM_PINS-1:0] = in_state;
         IDX_OUT_VALUE: rd_val[NUM_PINS-1:0] = out_value;
         IDX_SHUTDOWN:  rd_val[DLY_W-1:0]    = shut_dly;
         IDX_LOCK:      rd_val[0]            = lock;
         default: begin
            rd_hit = 1'b0;
            for (int i = 0; i < NUM_PINS; i++) begin
               if (idx == IDX_CONFIG0 + 10'(i)) begin
                  rd_val[7:0] = cfg[i];
                  rd_hit      = aligned;
               end
               if (idx == IDX_ON_DLY0 + 10'(i)) begin
                  rd_val[DLY_W-1:0] = on_dly[i];
                  rd_hit            = aligned;
               end
               if (idx == IDX_OFF_DLY0 + 10'(i)) begin
                  rd_val[DLY_W-1:0] = off_dly[i];
                  rd_hit            = aligned;
               end
            end
         end
      endcase
   end

   // answer in the first access cycle
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr <= !rd_hit;
         end
      end
   end

   // power request front end
   logic              pwr_act;
   logic              pb_mode;
   logic [HOLD_W-1:0] pb_cnt;
   logic [HOLD_W-1:0] hold_ms;
   logic              pb_seen;
   logic              pb_req;
   logic              req_int;
   assign pb_mode = ctrl[CTRL_PB_MODE];
   assign pwr_act = (pwr_s == ctrl[CTRL_PWR_POL]);

   always_comb begin
      case (ctrl[CTRL_HOLD_LO +: 2])
         2'h0:    hold_ms = HOLD_1000_MS;
         2'h1:    hold_ms = HOLD_1500_MS;
         2'h2:    hold_ms = HOLD_2000_MS;
         default: hold_ms = HOLD_3000_MS;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pb_cnt  <= '0;
         pb_seen <= 1'b0;
         pb_req  <= 1'b0;
      end else if (!pwr_act || !pb_mode) begin
         pb_cnt  <= '0;
         pb_seen <= 1'b0;
      end else if (ms_tick && !pb_seen) begin
         if (pb_cnt + 12'h001 >= hold_ms) begin
            pb_req  <= !pb_req;
            pb_seen <= 1'b1;
         end else begin
            pb_cnt <= pb_cnt + 12'h001;
         end
      end
   end
   assign req_int = pb_mode ? pb_req : pwr_act;

   logic seq_req;
   assign seq_req = ce_s && req_int && !fault_in && !ctrl[CTRL_BUS_RESET] && !ctrl[CTRL_COLD_RESET];

   // sequencer
   prs_state_type state;
   prs_state_type next_state;
   logic          down_by_ce;
   logic [9:0]    wake_cnt;
   logic [DLY_W-1:0] shut_cnt;
   logic          all_done;
   logic          seq_start;

   always_comb begin
      next_state = state;
      case (state)
         ST_OFF:      if (ce_s) next_state = ST_STANDBY;
         ST_STANDBY: begin
            if (!ce_s) next_state = ST_OFF;
            else if (seq_req) next_state = ST_WAKE;
         end
         ST_WAKE: begin
            if (!seq_req) next_state = ST_STANDBY;
            else if (wake_cnt == 10'(WAKE_CYCLES - 1)) next_state = ST_POWER_UP;
         end
         ST_POWER_UP: begin
            if (!seq_req) next_state = ST_POWER_DOWN;
            else if (all_done) next_state = ST_ACTIVE;
         end
         ST_ACTIVE:   if (!seq_req) next_state = ST_POWER_DOWN;
         ST_POWER_DOWN: begin
            if (down_by_ce && seq_req) next_state = ST_POWER_UP;
            else if (all_done) next_state = down_by_ce ? ST_SHUTDOWN : ST_STANDBY;
         end
         ST_SHUTDOWN: if (shut_cnt >= shut_dly) next_state = ST_STANDBY;
         default:     next_state = ST_OFF;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         down_by_ce <= 1'b0;
      end else if (next_state == ST_POWER_DOWN && state != ST_POWER_DOWN) begin
         down_by_ce <= !ce_s;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || state != ST_WAKE) begin
         wake_cnt <= '0;
      end else begin
         wake_cnt <= wake_cnt + 10'h001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || state != ST_SHUTDOWN) begin
         shut_cnt <= '0;
      end else if (ms_tick) begin
         shut_cnt <= shut_cnt + 7'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      seq_start <= !sys_rst && (next_state != state) &&
                   (next_state == ST_POWER_UP || next_state == ST_POWER_DOWN);
   end

   // per-pin sequencing and pin drive
   prs_timer_if tif[NUM_PINS] ();
   logic              powering_up;
   logic [NUM_PINS-1:0] tmr_done;
   logic [NUM_PINS-1:0] pin_done;
   logic [NUM_PINS-1:0] pin_late;
   logic [NUM_PINS-1:0] pin_assert_in;
   logic [DLY_W-1:0]  cur_dly [NUM_PINS];
   assign powering_up = (state == ST_POWER_UP);
   assign all_done    = &pin_done && !seq_start;

   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      prs_func_type  fn;
      prs_drive_type dt;
      logic          pol;
      logic          seq_on;
      logic          asserted;
      logic          level;
      logic          is_out;
      logic          hold_i;
      assign fn  = prs_func_type'(cfg[i][CFG_FUNC_LO +: 4]);
      assign dt  = prs_drive_type'(cfg[i][CFG_TYPE_LO +: 2]);
      assign pol = cfg[i][CFG_POL];
      assign cur_dly[i]       = powering_up ? on_dly[i] : off_dly[i];
      assign pin_assert_in[i] = (pin_s[i] == pol);
      assign in_state[i]      = (fn == FN_GP_IN) ? pin_s[i] : 1'b0;
      assign pin_late[i]      = (fn == FN_PGOOD_IN) && tmr_done[i] &&
                                (pin_assert_in[i] != powering_up);
      assign pin_done[i]      = tmr_done[i] && !pin_late[i];

      always_comb begin
         hold_i = 1'b0;
         for (int j = 0; j < NUM_PINS; j++) begin
            if (pin_late[j] && cur_dly[i] > cur_dly[j]) hold_i = 1'b1;
         end
      end

      assign tif[i].clr   = seq_start;
      assign tif[i].hold  = hold_i;
      assign tif[i].tick  = ms_tick;
      assign tif[i].limit = cur_dly[i];
      assign tmr_done[i]  = tif[i].done;

      prs_delay_timer u_timer (
         .sys_clk (sys_clk),
         .sys_rst (sys_rst),
         .tif     (tif[i])
      );

      always_ff @(posedge sys_clk) begin
         if (sys_rst) begin
            cfg[i]     <= CFG_RESET;
            on_dly[i]  <= DLY_RESET;
            off_dly[i] <= DLY_RESET;
         end else if (wr_en && !lock) begin
            if (idx == IDX_CONFIG0 + 10'(i))  cfg[i]     <= pwdata[7:0];
            if (idx == IDX_ON_DLY0 + 10'(i))  on_dly[i]  <= pwdata[DLY_W-1:0];
            if (idx == IDX_OFF_DLY0 + 10'(i)) off_dly[i] <= pwdata[DLY_W-1:0];
         end
      end

      always_comb begin
         case (state)
            ST_POWER_UP:   seq_on = tmr_done[i] && !seq_start;
            ST_ACTIVE:     seq_on = 1'b1;
            ST_POWER_DOWN: seq_on = !(tmr_done[i] && !seq_start);
            default:       seq_on = 1'b0;
         endcase
         is_out   = 1'b1;
         asserted = 1'b0;
         case (fn)
            FN_PGOOD_OUT: asserted = rail_good_in[i];
            FN_RESET_OUT: asserted = !seq_on;
            FN_VREN_OUT:  asserted = seq_on;
            FN_GP_OUT:    asserted = out_value[i];
            FN_CLK_OUT: begin
               is_out   = (i == 2);
               asserted = lfc_s;
            end
            default:      is_out = 1'b0;
         endcase
         level = (fn == FN_GP_OUT || fn == FN_CLK_OUT) ? asserted : (asserted == pol);
      end

      always_ff @(posedge sys_clk) begin
         if (sys_rst || state == ST_OFF || !is_out) begin
            multi_io_pin_out[i] <= 1'b0;
            multi_io_pin_oe[i]  <= 1'b0;
         end else begin
            case (dt)
               DRV_PULL_DOWN: begin
                  multi_io_pin_out[i] <= 1'b0;
                  multi_io_pin_oe[i]  <= !level;
               end
               DRV_PULL_UP: begin
                  multi_io_pin_out[i] <= 1'b1;
                  multi_io_pin_oe[i]  <= level;
               end
               DRV_PUSH_PULL: begin
                  multi_io_pin_out[i] <= level;
                  multi_io_pin_oe[i]  <= 1'b1;
               end
               default: begin
                  multi_io_pin_out[i] <= 1'b0;
                  multi_io_pin_oe[i]  <= 1'b0;
               end
            endcase
         end
      end
   end

   // pin-specific inputs and sequencer outputs
   logic [NUM_PINS-1:0] prev_assert;
   for (genvar k = 0; k < NUM_PINS; k++) begin : g_prev
      assign prev_assert[k] = (pin_prev[k] == cfg[k][CFG_POL]);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sleep_req               <= 1'b0;
         watchdog_kick_in        <= 1'b0;
         host_reset_in           <= 1'b0;
         rail_enable             <= 1'b0;
         discharge_enable        <= 1'b0;
         sequencer_power_request <= 1'b0;
         seq_state               <= ST_OFF;
      end else begin
         sleep_req <= (cfg[3][CFG_FUNC_LO +: 4] == FN_SLEEP_IN) && pin_assert_in[3];
         watchdog_kick_in <= (cfg[4][CFG_FUNC_LO +: 4] == FN_WDOG_IN) && pin_assert_in[4] && !prev_assert[4];
         host_reset_in <= (cfg[5][CFG_FUNC_LO +: 4] == FN_HRST_IN) && pin_assert_in[5] && !prev_assert[5];
         rail_enable <= (next_state == ST_POWER_UP || next_state == ST_ACTIVE ||
                         next_state == ST_POWER_DOWN);
         discharge_enable <= (next_state == ST_POWER_DOWN || next_state == ST_SHUTDOWN);
         sequencer_power_request <= seq_req;
         seq_state <= next_state;
      end
   end
endmodule

/* File: rtl/prs_pkg.sv */
// prs_pkg: constants, register map and types for the power request and multi-io control block
// assumes a 10 MHz system clock and a 32-bit apb master
package prs_pkg;
   localparam int NUM_PINS = 6;
   localparam int DLY_W    = 7;
   localparam int ADDR_W   = 12;
   localparam int IDX_W    = 10;
   localparam int HOLD_W   = 12;

   // timing
   localparam int CLK_NS       = 100;
   localparam int MS_NS        = 1000000;
   localparam int MS_CYCLES    = (MS_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAKE_NS      = 80000;
   localparam int WAKE_CYCLES  = (WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [HOLD_W-1:0] HOLD_1000_MS = 12'h3E8;
   localparam logic [HOLD_W-1:0] HOLD_1500_MS = 12'h5DC;
   localparam logic [HOLD_W-1:0] HOLD_2000_MS = 12'h7D0;
   localparam logic [HOLD_W-1:0] HOLD_3000_MS = 12'hBB8;

   // register indexes, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CTRL      = 10'h080;
   localparam logic [IDX_W-1:0] IDX_STATUS    = 10'h081;
   localparam logic [IDX_W-1:0] IDX_IN_STATE  = 10'h084;
   localparam logic [IDX_W-1:0] IDX_OUT_VALUE = 10'h085;
   localparam logic [IDX_W-1:0] IDX_SHUTDOWN  = 10'h086;
   localparam logic [IDX_W-1:0] IDX_LOCK      = 10'h088;
   localparam logic [IDX_W-1:0] IDX_CONFIG0   = 10'h08A;
   localparam logic [IDX_W-1:0] IDX_ON_DLY0   = 10'h090;
   localparam logic [IDX_W-1:0] IDX_OFF_DLY0  = 10'h096;

   // control register fields
   localparam int CTRL_PB_MODE    = 0;
   localparam int CTRL_PWR_POL    = 1;
   localparam int CTRL_HOLD_LO    = 2;
   localparam int CTRL_BUS_RESET  = 4;
   localparam int CTRL_COLD_RESET = 5;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // io config register fields
   localparam int CFG_FUNC_LO = 0;
   localparam int CFG_POL     = 4;
   localparam int CFG_TYPE_LO = 5;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [DLY_W-1:0] DLY_RESET = 7'h00;

   typedef enum logic [3:0] {
      FN_DISABLED  = 4'h0,
      FN_PGOOD_IN  = 4'h1,
      FN_GP_IN     = 4'h2,
      FN_PGOOD_OUT = 4'h3,
      FN_RESET_OUT = 4'h4,
      FN_VREN_OUT  = 4'h5,
      FN_GP_OUT    = 4'h6,
      FN_CLK_OUT   = 4'h7,
      FN_SLEEP_IN  = 4'h8,
      FN_WDOG_IN   = 4'h9,
      FN_HRST_IN   = 4'hA
   } prs_func_type;

   typedef enum logic [1:0] {
      DRV_HIGHZ     = 2'h0,
      DRV_PULL_DOWN = 2'h1,
      DRV_PULL_UP   = 2'h2,
      DRV_PUSH_PULL = 2'h3
   } prs_drive_type;

   typedef enum logic [6:0] {
      ST_OFF        = 7'h01,
      ST_STANDBY    = 7'h02,
      ST_WAKE       = 7'h04,
      ST_POWER_UP   = 7'h08,
      ST_ACTIVE     = 7'h10,
      ST_POWER_DOWN = 7'h20,
      ST_SHUTDOWN   = 7'h40
   } prs_state_type;
endpackage

/* File: rtl/prs_timer_if.sv */
// prs_timer_if: control and status of one per-pin sequence delay timer
// assumes the sequencer drives all controls on sys_clk
`timescale 1ns/1ps
interface prs_timer_if;
   import prs_pkg::*;
   logic             clr;
   logic             hold;
   logic             tick;
   logic [DLY_W-1:0] limit;
   logic             done;
   modport seq (output clr, output hold, output tick, output limit, input done);
   modport tmr (input clr, input hold, input tick, input limit, output done);
endinterface

/* File: rtl/prs_delay_timer.sv */
// prs_delay_timer: millisecond delay counter that can be frozen
// assumes tick is a one-cycle millisecond enable on sys_clk
`timescale 1ns/1ps
module prs_delay_timer (
   // clock and reset
   input wire logic  sys_clk,
   input wire logic  sys_rst,
   // control
   prs_timer_if.tmr  tif
);
   import prs_pkg::*;
   logic [DLY_W-1:0] count;

   assign tif.done = (count >= tif.limit);

   always_ff @(posedge sys_clk) begin
      if (sys_rst || tif.clr) begin
         count <= '0;
      end else if (tif.tick && !tif.hold && !tif.done) begin
         count <= count + 7'h01;
      end
   end
endmodule

/* File: testbench/prs_power_ctrl_chk.sv */
// prs_power_ctrl_chk: port assertions for prs_power_ctrl
// assumes it is bound to the design top, one clock domain
`timescale 1ns/1ps
module prs_power_ctrl_chk (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       sys_rst,
   // watched ports
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       rail_enable,
   input wire logic       discharge_enable,
   input wire logic [5:0] multi_io_pin_oe,
   input wire logic [6:0] seq_state
);
   int wcnt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // cycles spent in wake
   always_ff @(posedge sys_clk) begin
      wcnt <= (sys_rst || seq_state != 7'h04) ? 0 : wcnt + 1;
   end
   a_apb_zero_wait: assert property (psel && !penable |=> pready)
      else $error("ready missing");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready too long");
   a_wake_entry: assert property ($rose(seq_state == 7'h04) |-> $past(seq_state) == 7'h02)
      else $error("wake not from standby");
   a_wake_length: assert property ($fell(seq_state == 7'h04) |-> wcnt inside {[790:810]})
      else $error("wake length wrong");
   a_up_entry: assert property ($rose(seq_state == 7'h08) |-> $past(seq_state) inside {7'h04, 7'h20})
      else $error("bad power-up entry");
   a_active_exit: assert property ($fell(seq_state == 7'h10) |-> seq_state == 7'h20)
      else $error("active left wrongly");
   a_shutdown_exit: assert property ($fell(seq_state == 7'h40) |-> seq_state == 7'h02)
      else $error("shutdown left wrongly");
   a_rails_on: assert property ((seq_state == 7'h10) [*2] |-> rail_enable)
      else $error("rails off in active");
   a_discharge_on: assert property ((seq_state == 7'h40) [*2] |-> discharge_enable)
      else $error("no discharge in shutdown");
   a_off_float: assert property ((seq_state == 7'h01) [*2] |-> multi_io_pin_oe == 6'h00)
      else $error("pins driven while off");
   cover property (seq_state == 7'h10);
   cover property (seq_state == 7'h40);
   cover property ($rose(seq_state == 7'h08) && $past(seq_state) == 7'h20);
endmodule

/* File: testbench/prs_rail_model.sv */
// prs_rail_model: external regulator whose power-good follows its enable late
// assumes the enable comes from a multi-io pin on sys_clk
`timescale 1ns/1ps
module prs_rail_model #(
   parameter int LAT = 80
) (
   input wire logic sys_clk,
   input wire logic en,
   output logic     pgood
);
   int n = 0;
   initial pgood = 0;
   always @(posedge sys_clk) begin
      n <= (en === pgood) ? 0 : n + 1;
      if (en !== pgood && n >= LAT - 1) pgood <= en;
   end
endmodule

/* File: testbench/prs_power_ctrl_test.sv */
// prs_power_ctrl_test: self-checking bench for prs_power_ctrl
// assumes MS_DIV of 10, so one ms is 10 cycles
`timescale 1ns/1ps
module prs_power_ctrl_test;
   import prs_pkg::*;
   logic        sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   // request idles high: its active level is low after reset
   logic        ce = 0, pb = 1, gp = 0, pg, pready, pslverr, rail_enable, e, slp, wdk, hrs;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic [5:0]  po, poe;
   logic [6:0]  st;
   int          mismatches = 0, checks_done = 0;
   always #50 sys_clk = ~sys_clk;
   // unused pin inputs 0 and 2 held de-asserted
   prs_power_ctrl #(.MS_DIV(10)) DUT (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .chip_enable_in(ce), .power_request_in(pb), .low_freq_clock_in(1'b0), .fault_in(1'b0),
      .rail_good_in(6'h00), .multi_io_pin_in({gp, gp, gp, 1'b0, pg, 1'b0}), .multi_io_pin_out(po),
      .multi_io_pin_oe(poe), .rail_enable, .discharge_enable(), .sequencer_power_request(), .seq_state(st),
      .sleep_req(slp), .watchdog_kick_in(wdk), .host_reset_in(hrs));
   prs_rail_model #(.LAT(80)) u_rail (.sys_clk, .en(po[0]), .pgood(pg));
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task automatic give_verdict;
      if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tmo;
      mismatches++;
      give_verdict;
   endtask
   task automatic apb(input bit w, input logic [9:0] i, input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge sys_clk) penable <= 1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) tmo();
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge sys_clk);
   endtask
   task automatic wst(input logic [6:0] v, input int lim);
      int n;
      n = 0;
      while (st !== v && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= lim) tmo();
   endtask
   task automatic t_regs;
      apb(0, IDX_CTRL, 0);
      chk(r, {24'h0, CTRL_RESET});
      apb(0, IDX_CONFIG0, 0);
      chk(r, {24'h0, CFG_RESET});
      apb(0, 10'h3FF, 0);
      chk({r[30:0], e}, 1);
   endtask
   task automatic t_pins;
      logic [7:0] cfg [6] = '{8'h75, 8'h11, 8'h74, 8'h02, 8'h36, 8'h00};
      for (int k = 0; k < 6; k++) apb(1, IDX_CONFIG0 + 10'(k), {24'h0, cfg[k]});
      apb(1, IDX_ON_DLY0 + 10'h1, 3);
      apb(1, IDX_ON_DLY0 + 10'h2, 10);
      apb(1, IDX_SHUTDOWN, 2);
      gp <= 1;
      repeat (4) @(posedge sys_clk);
      apb(0, IDX_IN_STATE, 0);
      chk(r, 32'h8);
      chk({poe[4], po[4]}, 2'b10);
      apb(1, IDX_OUT_VALUE, 32'h10);
      repeat (2) @(posedge sys_clk);
      chk({poe[5], poe[4], poe[1]}, 0);
   endtask
   task automatic t_power;
      apb(1, IDX_CTRL, 32'h2);
      pb <= 1;
      wst(7'h08, 1000);
      repeat (120) @(posedge sys_clk);
      chk(po[2], 1);
      wst(7'h10, 400);
      chk({rail_enable, po[2], po[0]}, 3'b101);
      pb <= 0;
      wst(7'h02, 2000);
      chk({rail_enable, po[2], po[0]}, 3'b010);
   endtask
   task automatic t_enable;
      pb <= 1;
      wst(7'h10, 2000);
      ce <= 0;
      wst(7'h20, 20);
      repeat (3) @(posedge sys_clk);
      ce <= 1;
      wst(7'h08, 50);
      chk(st, 7'h08);
      wst(7'h10, 400);
      ce <= 0;
      wst(7'h01, 3000);
      repeat (2) @(posedge sys_clk);
      chk({poe, rail_enable}, 0);
      ce <= 1;
      pb <= 0;
   endtask
   task automatic t_button;
      apb(1, IDX_CTRL, 32'h3);
      pb <= 1;
      repeat (6000) @(posedge sys_clk);
      pb <= 0;
      repeat (5) @(posedge sys_clk);
      chk(st, 7'h02);
      pb <= 1;
      wst(7'h04, 10100);
      chk(st, 7'h04);
      pb <= 0;
   endtask
   task automatic t_special;
      apb(1, IDX_CONFIG0 + 10'h3, 32'h18);
      apb(1, IDX_CONFIG0 + 10'h4, 32'h19);
      apb(1, IDX_CONFIG0 + 10'h5, 32'h1A);
      gp <= 0;
      repeat (4) @(posedge sys_clk);
      chk(slp, 0);
      gp <= 1;
      repeat (4) @(posedge sys_clk);
      chk({slp, wdk, hrs}, 3'b111);
      @(posedge sys_clk);
      chk({slp, wdk, hrs}, 3'b100);
   endtask
   task automatic t_lock;
      apb(1, IDX_LOCK, 1);
      apb(1, IDX_CONFIG0, 0);
      apb(0, IDX_CONFIG0, 0);
      chk(r, 32'h75);
      apb(1, IDX_LOCK, 0);
      apb(0, IDX_STATUS, 0);
      chk(r, 32'h184);
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      sys_rst <= 0;
      ce <= 1;
      wst(7'h02, 100);
      t_regs;
      t_pins;
      t_power;
      t_enable;
      wst(7'h02, 200);
      t_button;
      t_special;
      t_lock;
      give_verdict;
   end
endmodule
bind prs_power_ctrl prs_power_ctrl_chk u_chk (.sys_clk, .sys_rst, .psel, .penable, .pready, .rail_enable,
   .discharge_enable, .multi_io_pin_oe, .seq_state);
